// [hdl/vpic_pkg.sv]
// Constants and carrier types for the vectored priority interrupt controller
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package vpic_pkg;
    // Geometry
    localparam int NUM_IN = 8;
    localparam int NUM_SRC = 16;
    localparam int SEL_W = 4;
    // Call opcode driven on the first acknowledge
    localparam logic [7:0] CALL_OPCODE = 8'hcd;
    // Control word addresses (a0 selects one of two ports)
    localparam logic ADDR_MODE = 1'b0;
    localparam logic ADDR_CTRL = 1'b1;
    // Control word port 1: mask register write
    // Control word port 0 data bits
    localparam int CW_ROT_BIT = 7;   // Rotating priority enable
    localparam int CW_SLV_BIT = 6;   // Off-board slaves present
    localparam int CW_STS_BIT = 5;   // Status select: 1 pending, 0 in service
    localparam int CW_BASE_LSB = 0;  // Base address page, bits 4:0
    localparam int CW_BASE_W = 5;
    // Reset values
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [7:0] BASE_RST = 8'h00;
    // Vector spacing: each level gets four bytes
    localparam int VEC_SHIFT = 2;

    // Host control lines carried together
    typedef struct packed {
        logic cs_n;   // Chip select
        logic rd_n;   // Read strobe
        logic wr_n;   // Write strobe
        logic a0;     // Port select
        logic ack_n;  // Interrupt acknowledge
    } host_ctl_s;

    // Acknowledge sequence states
    typedef enum logic [1:0] {
        ACK_IDLE,
        ACK_ONE,
        ACK_TWO,
        ACK_THREE
    } ack_state_e;
endpackage : vpic_pkg

// [hdl/pin_sync3.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Raw pins and filtered level
    input wire logic [W-1:0] pin_i,
    input wire logic [W-1:0] rst_val_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_ff;  // First stage, read by s2 only
    logic [W-1:0] s2_ff;  // Second stage
    logic [W-1:0] s3_ff;  // Third stage
    // --------------------------------------------------------------
    // Shift chain and agreement filter
    // --------------------------------------------------------------
    // Stages start at the pin's idle level, so no edge follows reset
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s1_ff <= rst_val_i;
            s2_ff <= rst_val_i;
            s3_ff <= rst_val_i;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    // Level moves only when stages two and three agree
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            level_o <= rst_val_i;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    level_o[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule : pin_sync3

// [hdl/vpic_top.sv]
// Vectored priority interrupt controller core
`timescale 1ns/1ps
module vpic_top #(
    parameter int N_IN = 8,
    parameter int N_SRC = 16
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Candidate request sources (asynchronous pins)
    input wire logic [N_SRC-1:0] src_req_i,
    // Static routing straps, one source index per input
    input wire logic [N_IN*vpic_pkg::SEL_W-1:0] route_sel_i,
    // Host control lines and data bus
    input wire vpic_pkg::host_ctl_s host_ctl_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_n_o,
    // Interrupt to processor and buffer enable
    output logic irq_o,
    output logic cascade_buffer_enable_n_o
);
    import vpic_pkg::*;

    // --------------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------------
    if (N_IN != NUM_IN || N_SRC != NUM_SRC) begin : g_bad_geom
        $error("Only eight inputs and sixteen sources are supported");
    end

    // --------------------------------------------------------------
    // Input synchronisation
    // --------------------------------------------------------------
    logic [N_SRC-1:0] src_lvl;   // Filtered source levels
    host_ctl_s hc;               // Filtered host lines
    host_ctl_s ctl_d_ff;         // Previous host lines
    pin_sync3 #(.W(N_SRC)) u_src_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .pin_i(src_req_i),
        .rst_val_i('0),
        .level_o(src_lvl)
    );
    // Host lines and data bus share one filter; lines idle high
    localparam int CTL_W = $bits(host_ctl_s);
    logic [CTL_W+7:0] bus_lvl;  // Filtered host lines over data
    pin_sync3 #(.W(CTL_W + 8)) u_ctl_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .pin_i({host_ctl_i, data_i}),
        .rst_val_i({{CTL_W{1'b1}}, 8'h00}),
        .level_o(bus_lvl)
    );
    assign hc = host_ctl_s'(bus_lvl[CTL_W+7:8]);
    logic [7:0] data_ff;  // Filtered data bus, one cycle behind
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctl_d_ff <= '1;
            data_ff <= 8'h00;
        end else begin
            ctl_d_ff <= hc;
            data_ff <= bus_lvl[7:0];
        end
    end
    logic ack_fall;  // Acknowledge goes low
    logic ack_rise;  // Acknowledge returns high
    logic wr_rise;   // Write strobe ends
    assign ack_fall = !hc.ack_n && ctl_d_ff.ack_n;
    assign ack_rise = hc.ack_n && !ctl_d_ff.ack_n;
    assign wr_rise = hc.wr_n && !ctl_d_ff.wr_n && !hc.cs_n;

    // --------------------------------------------------------------
    // Routing matrix
    // --------------------------------------------------------------
    logic [N_IN-1:0] routed;  // Request per controller input
    always_comb begin
        for (int i = 0; i < N_IN; i++) begin
            routed[i] = src_lvl[route_sel_i[i*SEL_W +: SEL_W]];
        end
    end

    // --------------------------------------------------------------
    // Programming registers
    // --------------------------------------------------------------
    logic [7:0] mask_ff;           // Per-input mask
    logic rot_ff;                  // Rotating priority on
    logic slaves_ff;               // Off-board slaves present
    logic sts_sel_ff;              // Status read selector
    logic [CW_BASE_W-1:0] base_ff; // Vector page
    logic [2:0] prio_top;          // Highest priority level now
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mask_ff <= MASK_RST;
            rot_ff <= 1'b0;
            slaves_ff <= 1'b0;
            sts_sel_ff <= 1'b0;
            base_ff <= BASE_RST[CW_BASE_W-1:0];
        end else if (wr_rise) begin
            if (hc.a0 == ADDR_CTRL) begin
                mask_ff <= data_ff;
            end else begin
                // Takes effect at once, no reset needed
                rot_ff <= data_ff[CW_ROT_BIT];
                slaves_ff <= data_ff[CW_SLV_BIT];
                sts_sel_ff <= data_ff[CW_STS_BIT];
                base_ff <= data_ff[CW_BASE_LSB +: CW_BASE_W];
            end
        end
    end

    // --------------------------------------------------------------
    // Pending set and arbitration
    // --------------------------------------------------------------
    logic [7:0] pend_ff;     // Latched pending requests
    logic [7:0] insvc_ff;    // In-service levels
    logic [7:0] rdy;         // Unmasked pending
    logic win_vld;           // A winner exists
    logic [2:0] win_lvl;     // Winning level
    logic [2:0] svc_lvl_ff;  // Level being serviced
    ack_state_e ack_ff;
    assign rdy = pend_ff & ~mask_ff;
    always_comb begin
        logic [2:0] idx;
        idx = 3'h0;
        win_vld = 1'b0;
        win_lvl = 3'h0;
        for (int k = N_IN - 1; k >= 0; k--) begin
            idx = 3'(prio_top + 3'(k));
            if (rdy[idx]) begin
                win_vld = 1'b1;
                win_lvl = idx;
            end
        end
    end
    // Pending: set wins over clear on the same cycle
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pend_ff <= 8'h00;
        end else begin
            for (int i = 0; i < N_IN; i++) begin
                if (routed[i]) begin
                    pend_ff[i] <= 1'b1;
                end else if (ack_fall && ack_ff == ACK_IDLE &&
                             win_vld && win_lvl == 3'(i)) begin
                    pend_ff[i] <= 1'b0;
                end
            end
        end
    end
    // In-service tracking; rotation follows the last served level
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            insvc_ff <= 8'h00;
            svc_lvl_ff <= 3'h0;
        end else if (ack_fall && ack_ff == ACK_IDLE) begin
            svc_lvl_ff <= win_lvl;
            insvc_ff <= 8'h01 << win_lvl;
        end else if (ack_rise && ack_ff == ACK_THREE) begin
            insvc_ff <= 8'h00;
        end
    end
    assign prio_top = rot_ff ? 3'(svc_lvl_ff + 3'h1) : 3'h0;

    // --------------------------------------------------------------
    // Acknowledge sequencer
    // --------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ack_ff <= ACK_IDLE;
        end else if (ack_fall) begin
            unique case (ack_ff)
                ACK_IDLE: ack_ff <= ACK_ONE;
                ACK_ONE: ack_ff <= ACK_TWO;
                ACK_TWO: ack_ff <= ACK_THREE;
                ACK_THREE: ack_ff <= ACK_ONE;
            endcase
        end else if (ack_rise && ack_ff == ACK_THREE) begin
            ack_ff <= ACK_IDLE;
        end
    end

    // --------------------------------------------------------------
    // Interrupt output
    // --------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else if (ack_fall || ack_ff != ACK_IDLE) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= win_vld;
        end
    end

    // --------------------------------------------------------------
    // Data bus drive
    // --------------------------------------------------------------
    logic [15:0] vec;  // Service routine address
    assign vec = {8'h00, base_ff, svc_lvl_ff} << VEC_SHIFT;
    logic answer;      // This pulse is ours to answer
    logic [7:0] ack_byte;
    always_comb begin
        answer = 1'b0;
        ack_byte = 8'h00;
        unique case (ack_ff)
            ACK_ONE: begin
                answer = 1'b1;
                ack_byte = CALL_OPCODE;
            end
            ACK_TWO: begin
                answer = !slaves_ff;
                ack_byte = vec[7:0];
            end
            ACK_THREE: begin
                answer = !slaves_ff;
                ack_byte = vec[15:8];
            end
            ACK_IDLE: answer = 1'b0;
        endcase
    end
    logic ack_low;
    logic rd_act;
    assign ack_low = !hc.ack_n && !ctl_d_ff.ack_n;
    assign rd_act = !hc.cs_n && !hc.rd_n && hc.ack_n;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            data_o <= 8'h00;
            data_oe_n_o <= 1'b1;
            cascade_buffer_enable_n_o <= 1'b1;
        end else if (ack_low && answer) begin
            data_o <= ack_byte;
            data_oe_n_o <= 1'b0;
            cascade_buffer_enable_n_o <= 1'b0;
        end else if (rd_act) begin
            // Status read
            data_o <= (hc.a0 == ADDR_CTRL) ? mask_ff :
                      (sts_sel_ff ? pend_ff : insvc_ff);
            data_oe_n_o <= 1'b0;
            cascade_buffer_enable_n_o <= 1'b0;
        end else begin
            data_oe_n_o <= 1'b1;
            cascade_buffer_enable_n_o <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    property p_irq_drop;
        @(posedge mclk_i) disable iff (reset_i)
        ack_fall |=> !irq_o;
    endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("irq stayed high after acknowledge");
    property p_call;
        @(posedge mclk_i) disable iff (reset_i)
        (ack_ff == ACK_ONE && ack_low) |=> (data_o == CALL_OPCODE);
    endproperty
    a_call: assert property (p_call)
        else $error("call opcode missing on first acknowledge");
    property p_buf_en;
        @(posedge mclk_i) disable iff (reset_i)
        (ack_low && answer) |=> !cascade_buffer_enable_n_o;
    endproperty
    a_buf_en: assert property (p_buf_en)
        else $error("buffer enable not low during answer");
    property p_slave_quiet;
        @(posedge mclk_i) disable iff (reset_i)
        (slaves_ff && ack_ff == ACK_TWO && ack_low && !rd_act)
            |=> data_oe_n_o;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet)
        else $error("master drove address with slaves");
    property p_lo_byte;
        @(posedge mclk_i) disable iff (reset_i)
        (!slaves_ff && ack_ff == ACK_TWO && ack_low) |=> data_o == vec[7:0];
    endproperty
    a_lo_byte: assert property (p_lo_byte)
        else $error("low address byte wrong");
    property p_idle_after;
        @(posedge mclk_i) disable iff (reset_i)
        (ack_rise && ack_ff == ACK_THREE) |=> ack_ff == ACK_IDLE;
    endproperty
    a_idle_after: assert property (p_idle_after)
        else $error("sequencer did not return to idle");
    property p_irq_cause;
        @(posedge mclk_i) disable iff (reset_i)
        $rose(irq_o) |-> $past(win_vld);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq raised without winner");
    property p_win_unmasked;
        @(posedge mclk_i) disable iff (reset_i)
        win_vld |-> rdy[win_lvl] &&
            (rot_ff || (rdy & ((8'h01 << win_lvl) - 8'h01)) == 8'h00);
    endproperty
    a_win_unmasked: assert property (p_win_unmasked)
        else $error("winner not ready or not highest");
endmodule : vpic_top

// [test/cpu_ack_model.sv]
// Processor model that answers an interrupt with three acknowledge pulses
`timescale 1ns/1ps
module cpu_ack_model (
    // Clock
    input wire logic mclk_i,
    // Controller outputs seen by the processor
    input wire logic irq_i,
    input wire logic [7:0] data_i,
    input wire logic oe_n_i,
    input wire logic buf_n_i,
    // Bench control and captured results
    input wire logic start_i,
    input wire logic [15:0] slave_addr_i,
    output logic irq_ack_n_o,
    output logic done_o,
    output logic [7:0] opcode_o,
    output logic [15:0] addr_o,
    output logic [2:0] oe_n_o,
    output logic [2:0] buf_n_o,
    output logic irq_late_o
);
    // ---------------------------------------------------------------
    // Pulse timing
    // ---------------------------------------------------------------
    localparam int LOW_CYC = 12;  // Long enough for the pin filter
    localparam int HIGH_CYC = 12; // Gap lets the outputs release
    logic [7:0] got_b [3];        // Byte latched at the end of each pulse

    // ---------------------------------------------------------------
    // Acknowledge sequencer
    // ---------------------------------------------------------------
    // Latch the bus just before each rising edge, then pulse again
    initial begin
        irq_ack_n_o = 1'b1;
        done_o = 1'b0;
        opcode_o = 8'h00;
        addr_o = 16'h0000;
        oe_n_o = 3'b111;
        buf_n_o = 3'b111;
        irq_late_o = 1'b0;
        forever begin
            @(posedge mclk_i);
            if (start_i === 1'b1) begin
                @(negedge mclk_i);
                done_o = 1'b0;
                // Opcode pulse, then exactly two more
                for (int p = 0; p < 3; p++) begin
                    irq_ack_n_o = 1'b0;
                    repeat (LOW_CYC) @(negedge mclk_i);
                    // Master silent: off-board slave drives
                    if (oe_n_i === 1'b0) begin
                        got_b[p] = data_i;
                    end else begin
                        got_b[p] = slave_addr_i[8 * (p / 2) +: 8];
                    end
                    oe_n_o[p] = oe_n_i;
                    buf_n_o[p] = buf_n_i;
                    irq_late_o = irq_i;
                    irq_ack_n_o = 1'b1;
                    repeat (HIGH_CYC) @(negedge mclk_i);
                end
                opcode_o = got_b[0];
                addr_o = {got_b[2], got_b[1]}; // Low byte came first
                done_o = 1'b1;
            end
        end
    end
endmodule : cpu_ack_model

// [test/tb_vectored_priority_interrupt_ctrl.sv]
// Self-checking bench for the vectored priority interrupt controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; \
    if ((got) !== (ex)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb_vectored_priority_interrupt_ctrl;
    import vpic_pkg::*;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic mclk_i = 1'b0;           // System clock
    logic reset_i = 1'b1;          // Synchronous reset
    logic [15:0] src_req = 16'h0;  // Request sources
    logic [31:0] route = 32'h0;    // Routing straps
    logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, a0 = 1'b0;
    logic [7:0] wdata = 8'h00;     // Host write data
    logic start = 1'b0;            // Kicks the processor model
    logic [15:0] slave_addr = 16'h0000; // Off-board slave's address
    logic ack_n, done, irq_late, irq, oe_n, buf_n;
    logic [7:0] rdata, opcode;
    logic [15:0] addr;
    logic [2:0] oe_seen, buf_seen;
    host_ctl_s host_ctl;           // Packed host control lines
    int num_errors = 0;
    int samples_checked = 0;
    assign host_ctl = {cs_n, rd_n, wr_n, a0, ack_n};
    always #5 mclk_i = ~mclk_i;

    // ---------------------------------------------------------------
    // Design and processor model
    // ---------------------------------------------------------------
    vpic_top #(.N_IN(8), .N_SRC(16)) dut (
        .mclk_i(mclk_i), .reset_i(reset_i), .src_req_i(src_req),
        .route_sel_i(route), .host_ctl_i(host_ctl), .data_i(wdata),
        .data_o(rdata), .data_oe_n_o(oe_n), .irq_o(irq),
        .cascade_buffer_enable_n_o(buf_n));
    cpu_ack_model cpu (
        .mclk_i(mclk_i), .irq_i(irq), .data_i(rdata), .oe_n_i(oe_n),
        .buf_n_i(buf_n), .start_i(start), .irq_ack_n_o(ack_n),
        .slave_addr_i(slave_addr),
        .done_o(done), .opcode_o(opcode), .addr_o(addr),
        .oe_n_o(oe_seen), .buf_n_o(buf_seen), .irq_late_o(irq_late));

    // ---------------------------------------------------------------
    // Host bus tasks
    // ---------------------------------------------------------------
    // Write one control word; data held well around the strobe rise
    task automatic host_wr(input logic sel, input logic [7:0] d);
        @(negedge mclk_i);
        cs_n = 1'b0;
        a0 = sel;
        wdata = d;
        repeat (6) @(negedge mclk_i);
        wr_n = 1'b0;
        repeat (6) @(negedge mclk_i);
        wr_n = 1'b1;
        repeat (6) @(negedge mclk_i);
        cs_n = 1'b1;
        repeat (4) @(negedge mclk_i);
    endtask : host_wr

    // Status read, checked while the strobe is still low
    task automatic host_rd(input logic sel, input logic [7:0] ex);
        @(negedge mclk_i);
        cs_n = 1'b0;
        rd_n = 1'b0;
        a0 = sel;
        repeat (10) @(negedge mclk_i);
        `CHK("status byte", ex, rdata)
        `CHK("status drive", 1'b0, oe_n)
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (8) @(negedge mclk_i);
    endtask : host_rd

    // Wait for the request, run the sequence, judge what came back
    task automatic serve(input logic [2:0] lvl, input logic [2:0] oe_ex,
                         input logic [15:0] drop);
        logic [15:0] va;
        int n;
        va = 16'({5'h0a, lvl}) << VEC_SHIFT;
        n = 0;
        while (irq !== 1'b1 && n < 60) begin
            @(negedge mclk_i);
            n++;
        end
        `CHK("irq raised", 1'b1, irq)
        // Source withdrawn first; the latched request keeps irq up
        src_req = src_req & ~drop;
        repeat (4) @(negedge mclk_i);
        `CHK("irq kept", 1'b1, irq)
        start = 1'b1;
        @(negedge mclk_i);
        start = 1'b0;
        repeat (8) @(negedge mclk_i);
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(negedge mclk_i);
            n++;
        end
        `CHK("sequence done", 1'b1, done)
        `CHK("call opcode", CALL_OPCODE, opcode)
        if (oe_ex == 3'b000) begin
            `CHK("vector", va, addr)
        end else begin
            `CHK("slave vector", slave_addr, addr)
        end
        `CHK("drive pattern", oe_ex, oe_seen)
        `CHK("buffer enable", 3'b000, buf_seen & ~oe_ex)
        `CHK("irq held low", 1'b0, irq_late)
        `CHK("idle release", 1'b1, oe_n & buf_n)
    endtask : serve

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    // Reset state, mask reset value and masked request ignored
    task automatic t_reset();
        `CHK("reset irq", 1'b0, irq)
        `CHK("reset data", 8'h00, rdata)
        `CHK("reset drive", 1'b1, oe_n & buf_n)
        host_rd(ADDR_CTRL, MASK_RST);
        src_req = 16'h0002;
        repeat (20) @(negedge mclk_i);
        `CHK("masked irq", 1'b0, irq)
        src_req = 16'h0000;
        repeat (8) @(negedge mclk_i);
        host_wr(ADDR_MODE, 8'h2a); // Master, status reads pending, base 0a
        host_wr(ADDR_CTRL, 8'hd5); // Unmask inputs 1, 3 and 5
        host_rd(ADDR_CTRL, 8'hd5);
        serve(3'd1, 3'b000, 16'h0000); // Masked request kept
        $display("test reset done");
    endtask : t_reset

    // Strap routing: source 3 is unrouted, source 9 feeds input 3
    task automatic t_route();
        src_req = 16'h0008;
        repeat (20) @(negedge mclk_i);
        `CHK("unrouted irq", 1'b0, irq)
        src_req = 16'h0200;
        repeat (20) @(negedge mclk_i);
        host_rd(ADDR_MODE, 8'h08); // Pending set
        serve(3'd3, 3'b000, 16'h0200);
        $display("test route done");
    endtask : t_route

    // Fixed then rotating priority, switched while running
    task automatic t_priority();
        src_req = 16'h0022;
        serve(3'd1, 3'b000, 16'h0000); // Lowest index first
        host_wr(ADDR_MODE, 8'h8a); // Rotation on, no reset
        host_rd(ADDR_MODE, 8'h00); // Nothing in service
        serve(3'd5, 3'b000, 16'h0020); // Served plus one leads
        host_wr(ADDR_MODE, 8'h0a); // Back to fixed
        serve(3'd1, 3'b000, 16'h0002);
        $display("test priority done");
    endtask : t_priority

    // Off-board slaves: master answers the opcode pulse only
    task automatic t_slaves();
        host_wr(ADDR_MODE, 8'h4a); // Bus-vectored cascade
        src_req = 16'h0020;
        slave_addr = 16'h5a3c; // Slave's service address
        serve(3'd5, 3'b110, 16'h0020);
        host_wr(ADDR_MODE, 8'h0a);
        $display("test slaves done");
    endtask : t_slaves

    // ---------------------------------------------------------------
    // Verdict and run control
    // ---------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    // Hang guard, several times the expected run
    initial begin
        #100us;
        num_errors++;
        conclude();
    end

    // Main sequence
    initial begin
        for (int i = 0; i < 8; i++) begin
            route[4*i +: 4] = 4'(i);
        end
        route[15:12] = 4'h9;
        repeat (3) @(negedge mclk_i);
        reset_i = 1'b0;
        repeat (6) @(negedge mclk_i);
        t_reset();
        t_route();
        t_priority();
        t_slaves();
        conclude();
    end
endmodule : tb_vectored_priority_interrupt_ctrl
